// ### hdl/ddp_map.svh
// Register offsets, field positions, reset values and sizes of the dispatch block
`ifndef DDP_MAP_SVH
`define DDP_MAP_SVH
`define DDP_EVT_LO    12'h000
`define DDP_EVT_HI    12'h004
`define DDP_CHN_LO    12'h008
`define DDP_CHN_HI    12'h00c
`define DDP_MAN_LO    12'h010
`define DDP_MAN_HI    12'h014
`define DDP_QEV       12'h018
`define DDP_SEC_LO    12'h01c
`define DDP_SEC_HI    12'h020
`define DDP_QSEC      12'h024
`define DDP_PEND_LO   12'h028
`define DDP_PEND_HI   12'h02c
`define DDP_QSEL0     12'h030
`define DDP_QQSEL     12'h040
`define DDP_PRIO      12'h044
`define DDP_STATUS    12'h048
`define DDP_PAR_BASE  12'h400
`define DDP_PAR_END   12'h880
`define DDP_OPT_NULL  31
`define DDP_OPT_EARLY 30
`define DDP_OPT_CHAIN 29
`define DDP_PRIO_RST  3'h0
`define DDP_QDEPTH    4
`define DDP_DSTDEPTH  2
`define DDP_DFDEPTH   8
`define DDP_QUICK_BASE 7'h40
`define DDP_WORD_STEP 32'h0000_0004
`endif

// ### hdl/ddp_pkg.sv
// Types shared by the event dispatch block
package ddp_pkg;
  `include "ddp_map.svh"

  typedef enum logic [1:0] {DDP_TRG_EVT, DDP_TRG_CHN, DDP_TRG_MAN, DDP_TRG_QCK} ddp_trg_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } ddp_wb_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } ddp_src_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
    logic [31:0] data;
  } ddp_dst_t;

  typedef struct packed {
    logic        quick;
    logic [5:0]  ch;
    ddp_trg_t    trg;
  } ddp_ent_t;

  typedef struct packed {
    logic        early;
    logic        chain;
    logic [5:0]  code;
    logic [15:0] cnt;
    logic [31:0] src;
    logic [31:0] dst;
  } ddp_tr_t;

  typedef struct packed {
    ddp_ent_t [`DDP_QDEPTH-1:0] ent;
    logic [1:0]                 wp;
    logic [1:0]                 rp;
    logic [2:0]                 cnt;
  } ddp_que_t;

  typedef struct packed {
    logic [63:0]                 evt;
    logic [63:0]                 chn;
    logic [63:0]                 man;
    logic [63:0]                 sec;
    logic [63:0]                 pend;
    logic [7:0]                  qev;
    logic [7:0]                  qsec;
    logic [127:0]                qsel;
    logic [15:0]                 qqsel;
    logic [2:0]                  prio;
    ddp_que_t [3:0]              que;
    logic                        ack;
    logic [31:0]                 rdat;
    ddp_tr_t                     prog;
    logic                        prog_v;
    logic                        src_v;
    logic [15:0]                 rd_left;
    logic [31:0]                 rd_addr;
    ddp_tr_t [`DDP_DSTDEPTH-1:0] dfr;
    logic                        dfr_rp;
    logic [1:0]                  dfr_cnt;
    logic [2:0]                  df_wp;
    logic [2:0]                  df_rp;
    logic [3:0]                  df_cnt;
    logic                        src_req;
    logic                        dst_req;
    logic [31:0]                 waddr;
    logic [31:0]                 wdat;
    logic                        cc_ack;
    logic                        tc_ack;
  } ddp_st_t;
endpackage

// ### hdl/ddp_top.sv
// Event latching, prioritisation, queueing, submission and transfer engine
//
// Summary of operation
// - Each trigger latches into its channel's event, chain, manual or quick flag.
// - Queued events set the secondary bit so arbitration skips that channel.
// - Empty controller and all four queues empty let the event bypass the queue.
// - Submission classifies each dequeued parameter set as null, dummy or real.
// - Non-null clears trigger flag and secondary bit; null leaves secondary set.
// - Only real requests go to the transfer controller.
// - Early completion sets pending bit of the code at submission time.
// - Normal completion sets pending bit when the controller returns the code.
// - Program slot moves on only when source and destination sets have room.
// - Read controller fetches from source and fills the data FIFO.
// - Write controller starts once one word sits in the FIFO.
// - Finishing all writes reports the completion code back.
// - Simultaneous channel events: lowest channel number is queued first.
// - Simultaneous quick events: lowest quick channel is queued first.
// - A channel event always goes ahead of a quick event.
// - Per channel: peripheral event, then chain, then manual trigger.
// - Queue select picks the queue; queue 0 dequeues first, queue 3 last.
// - Controller drives programmable fabric priority, reset value 0.
// - Logic runs on the processor clock divided by three.
// - Reset clears controllers and registers, not parameter memory.
// - Separate stop requests idle the channel and transfer controllers.
// - Processor emulation halt does not stop any of this logic.
//
// Our own choices: register access over Wishbone and the placing of the registers.
`include "ddp_map.svh"

module ddp_top (
  input  wire logic             CORE_CLK,
  input  wire logic             ARST_N,
  input  wire ddp_pkg::ddp_wb_t WB_I,
  output logic                  WB_ACK,
  output logic [31:0]           WB_DAT,
  input  wire logic [63:0]      EVT_IN,
  output ddp_pkg::ddp_src_t     SRC_O,
  input  wire logic             SRC_ACK,
  input  wire logic [31:0]      SRC_RDATA,
  output ddp_pkg::ddp_dst_t     DST_O,
  input  wire logic             DST_ACK,
  output logic [2:0]            SYS_PRIO,
  input  wire logic             STOP_REQ_CC,
  input  wire logic             STOP_REQ_TC,
  output logic                  STOP_ACK_CC,
  output logic                  STOP_ACK_TC
);
  import ddp_pkg::*;

  // ------------------------------------------------------------
  // Storage and working signals
  // ------------------------------------------------------------
  ddp_st_t     s;
  ddp_st_t     n;
  logic [31:0] pmem  [0:287];
  logic [31:0] dfifo [0:`DDP_DFDEPTH-1];

  logic        hit;
  logic        wr;
  logic [31:0] wmk;
  logic [31:0] wmd;
  logic [11:0] poff;
  logic [8:0]  pidx;
  logic        phit;
  logic [31:0] pmw;
  logic [31:0] rd;
  logic [63:0] evt_c;
  logic [63:0] chn_s;
  logic [63:0] chn_c;
  logic [63:0] man_s;
  logic [63:0] man_c;
  logic [63:0] sec_s;
  logic [63:0] sec_c;
  logic [63:0] pend_s;
  logic [63:0] pend_c;
  logic [7:0]  qev_s;
  logic [7:0]  qev_c;
  logic [7:0]  qsec_s;
  logic [7:0]  qsec_c;
  logic [6:0]  df;
  logic [6:0]  qf;
  ddp_ent_t    ent;
  ddp_ent_t    se;
  logic [1:0]  tq;
  logic [1:0]  hq;
  logic        enq;
  logic        anyq;
  logic        take;
  logic        byp;
  logic        sub;
  logic        push_q;
  logic        pop_q;
  logic [6:0]  sidx;
  ddp_tr_t     tr;
  logic        nul;
  logic        dum;
  ddp_tr_t     hd;
  logic        idle;
  logic        df_push;
  logic        df_pop;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Lowest set bit wins, so channel 0 is the most urgent
  function automatic logic [6:0] ddp_first(input logic [63:0] v);
    ddp_first = 7'h00;
    for (int i = 63; i >= 0; i--) begin
      if (v[i]) ddp_first = {1'b1, 6'(i)};
    end
  endfunction

  function automatic logic [31:0] ddp_bmask(input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      ddp_bmask[i*8 +: 8] = {8{sel[i]}};
    end
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    n      = s;
    evt_c  = '0;
    chn_s  = '0;
    chn_c  = '0;
    man_s  = '0;
    man_c  = '0;
    sec_s  = '0;
    sec_c  = '0;
    pend_s = '0;
    pend_c = '0;
    qev_s  = '0;
    qev_c  = '0;
    qsec_s = '0;
    qsec_c = '0;

    // Bus decode; writes land on the acknowledging edge
    hit  = WB_I.cyc & WB_I.stb;
    wr   = hit & WB_I.we & s.ack;
    wmk  = ddp_bmask(WB_I.sel);
    wmd  = WB_I.dat & wmk;
    poff = WB_I.adr - `DDP_PAR_BASE;
    pidx = poff[10:2];
    phit = (WB_I.adr >= `DDP_PAR_BASE) && (WB_I.adr < `DDP_PAR_END);
    pmw  = (pmem[pidx] & ~wmk) | wmd;
    n.ack = hit & ~s.ack;

    // Read mux
    case ({WB_I.adr[11:2], 2'b00})
      `DDP_EVT_LO:  rd = s.evt[31:0];
      `DDP_EVT_HI:  rd = s.evt[63:32];
      `DDP_CHN_LO:  rd = s.chn[31:0];
      `DDP_CHN_HI:  rd = s.chn[63:32];
      `DDP_MAN_LO:  rd = s.man[31:0];
      `DDP_MAN_HI:  rd = s.man[63:32];
      `DDP_QEV:     rd = {24'h0, s.qev};
      `DDP_SEC_LO:  rd = s.sec[31:0];
      `DDP_SEC_HI:  rd = s.sec[63:32];
      `DDP_QSEC:    rd = {24'h0, s.qsec};
      `DDP_PEND_LO: rd = s.pend[31:0];
      `DDP_PEND_HI: rd = s.pend[63:32];
      12'h030:      rd = s.qsel[31:0];
      12'h034:      rd = s.qsel[63:32];
      12'h038:      rd = s.qsel[95:64];
      12'h03c:      rd = s.qsel[127:96];
      `DDP_QQSEL:   rd = {16'h0, s.qqsel};
      `DDP_PRIO:    rd = {29'h0, s.prio};
      `DDP_STATUS:  rd = {8'h0, s.que[3].cnt, s.que[2].cnt, s.que[1].cnt, s.que[0].cnt,
                          2'b00, s.cc_ack, s.tc_ack, s.prog_v, s.src_v, s.dfr_cnt, s.df_cnt};
      default:      rd = phit ? pmem[pidx] : 32'h0000_0000;
    endcase
    if (hit & ~s.ack) n.rdat = rd;

    // Register writes: flags clear by writing ones, manual set by writing ones
    if (wr) begin
      case ({WB_I.adr[11:2], 2'b00})
        `DDP_EVT_LO:  evt_c[31:0] = wmd;
        `DDP_EVT_HI:  evt_c[63:32] = wmd;
        `DDP_CHN_LO:  chn_c[31:0] = wmd;
        `DDP_CHN_HI:  chn_c[63:32] = wmd;
        `DDP_MAN_LO:  man_s[31:0] = wmd;
        `DDP_MAN_HI:  man_s[63:32] = wmd;
        `DDP_QEV:     qev_c = wmd[7:0];
        `DDP_SEC_LO:  sec_c[31:0] = wmd;
        `DDP_SEC_HI:  sec_c[63:32] = wmd;
        `DDP_QSEC:    qsec_c = wmd[7:0];
        `DDP_PEND_LO: pend_c[31:0] = wmd;
        `DDP_PEND_HI: pend_c[63:32] = wmd;
        12'h030:      n.qsel[31:0] = (s.qsel[31:0] & ~wmk) | wmd;
        12'h034:      n.qsel[63:32] = (s.qsel[63:32] & ~wmk) | wmd;
        12'h038:      n.qsel[95:64] = (s.qsel[95:64] & ~wmk) | wmd;
        12'h03c:      n.qsel[127:96] = (s.qsel[127:96] & ~wmk) | wmd;
        `DDP_QQSEL:   n.qqsel = (s.qqsel & ~wmk[15:0]) | wmd[15:0];
        `DDP_PRIO:    n.prio = (s.prio & ~wmk[2:0]) | wmd[2:0];
        default:      ;
      endcase
      // Writing the last word of a quick set fires that quick channel
      if (phit && pidx[8] && pidx[1:0] == 2'h3) qev_s[pidx[4:2]] = 1'b1;
    end

    // Event arbitration; latching continues under any processor halt
    df = ddp_first((s.evt | s.chn | s.man) & ~s.sec);
    qf = ddp_first({56'h0, s.qev & ~s.qsec});
    ent = '0;
    tq  = 2'h0;
    if (df[6]) begin
      ent.ch = df[5:0];
      if (s.evt[df[5:0]]) ent.trg = DDP_TRG_EVT;
      else if (s.chn[df[5:0]]) ent.trg = DDP_TRG_CHN;
      else ent.trg = DDP_TRG_MAN;
      tq = s.qsel[{df[5:0], 1'b0} +: 2];
    end else if (qf[6]) begin
      ent.quick = 1'b1;
      ent.ch    = qf[5:0];
      ent.trg   = DDP_TRG_QCK;
      tq        = s.qqsel[{qf[2:0], 1'b0} +: 2];
    end
    enq = (df[6] | qf[6]) & ~STOP_REQ_CC;

    // Dequeue: best non-empty queue whenever the program slot is free and STOP_REQ_CC is low
    hq   = 2'h0;
    anyq = 1'b0;
    for (int k = 3; k >= 0; k--) begin
      if (s.que[k].cnt != 3'h0) begin
        hq   = 2'(k);
        anyq = 1'b1;
      end
    end
    take = ~s.prog_v & ~STOP_REQ_CC;
    idle = ~s.prog_v & ~s.src_v & (s.dfr_cnt == 2'h0) & ~s.src_req & ~s.dst_req;
    byp  = enq & take & idle & ~anyq & (s.que[tq].cnt == 3'h0);
    pop_q  = take & anyq & ~byp;
    sub    = byp | pop_q;
    se     = byp ? ent : s.que[hq].ent[s.que[hq].rp];
    push_q = enq & ~byp & (s.que[tq].cnt != 3'(`DDP_QDEPTH));
    if (push_q) begin
      if (ent.quick) qsec_s[ent.ch[2:0]] = 1'b1;
      else sec_s[ent.ch] = 1'b1;
    end

    // Queue pointers; a full queue leaves the event latched for a retry
    for (int k = 0; k < 4; k++) begin
      if (push_q && tq == 2'(k)) begin
        n.que[k].ent[s.que[k].wp] = ent;
        n.que[k].wp = s.que[k].wp + 2'h1;
      end
      if (pop_q && hq == 2'(k)) n.que[k].rp = s.que[k].rp + 2'h1;
      n.que[k].cnt = s.que[k].cnt + 3'(push_q && tq == 2'(k)) - 3'(pop_q && hq == 2'(k));
    end

    // Submission: read the set and classify it
    sidx     = se.quick ? `DDP_QUICK_BASE + {4'h0, se.ch[2:0]} : {1'b0, se.ch};
    tr.early = pmem[{sidx, 2'h0}][`DDP_OPT_EARLY];
    tr.chain = pmem[{sidx, 2'h0}][`DDP_OPT_CHAIN];
    tr.code  = pmem[{sidx, 2'h0}][5:0];
    tr.cnt   = pmem[{sidx, 2'h1}][15:0];
    tr.src   = pmem[{sidx, 2'h2}];
    tr.dst   = pmem[{sidx, 2'h3}];
    nul = pmem[{sidx, 2'h0}][`DDP_OPT_NULL];
    dum = ~nul & (tr.cnt == 16'h0000);
    if (sub && nul && byp) begin
      // Null set: the channel stays blocked until software clears it
      if (se.quick) qsec_s[se.ch[2:0]] = 1'b1;
      else sec_s[se.ch] = 1'b1;
    end
    if (sub && !nul) begin
      case (se.trg)
        DDP_TRG_EVT: evt_c[se.ch] = 1'b1;
        DDP_TRG_CHN: chn_c[se.ch] = 1'b1;
        DDP_TRG_MAN: man_c[se.ch] = 1'b1;
        default:     qev_c[se.ch[2:0]] = 1'b1;
      endcase
      if (se.quick) qsec_c[se.ch[2:0]] = 1'b1;
      else sec_c[se.ch] = 1'b1;
      if (!dum) begin
        n.prog   = tr;
        n.prog_v = 1'b1;
        if (tr.early) pend_s[tr.code] = 1'b1;
      end
    end

    // Program slot to source active and destination sets
    if (s.prog_v && !s.src_v && s.dfr_cnt != 2'(`DDP_DSTDEPTH) && !STOP_REQ_TC) begin
      n.prog_v  = 1'b0;
      n.src_v   = 1'b1;
      n.rd_left = s.prog.cnt;
      n.rd_addr = s.prog.src;
      n.dfr[s.dfr_rp ^ s.dfr_cnt[0]] = s.prog;
    end

    // Read controller: one read outstanding, only while the FIFO has room
    df_push = s.src_req & SRC_ACK;
    if (s.src_v && !s.src_req && s.df_cnt != 4'(`DDP_DFDEPTH)) n.src_req = 1'b1;
    if (df_push) begin
      n.src_req = 1'b0;
      n.df_wp   = s.df_wp + 3'h1;
      n.rd_addr = s.rd_addr + `DDP_WORD_STEP;
      n.rd_left = s.rd_left - 16'h0001;
      if (s.rd_left == 16'h0001) n.src_v = 1'b0;
    end

    // Write controller: starts on the first buffered word, not after all reads
    hd     = s.dfr[s.dfr_rp];
    df_pop = (s.dfr_cnt != 2'h0) & ~s.dst_req & (s.df_cnt != 4'h0);
    if (df_pop) begin
      n.dst_req = 1'b1;
      n.waddr   = hd.dst;
      n.wdat    = dfifo[s.df_rp];
      n.df_rp   = s.df_rp + 3'h1;
    end
    n.df_cnt = s.df_cnt + 4'(df_push) - 4'(df_pop);
    n.dfr_cnt = s.dfr_cnt + 2'(s.prog_v && !s.src_v && s.dfr_cnt != 2'(`DDP_DSTDEPTH)
                && !STOP_REQ_TC);
    if (s.dst_req && DST_ACK) begin
      n.dst_req = 1'b0;
      n.dfr[s.dfr_rp].cnt = hd.cnt - 16'h0001;
      n.dfr[s.dfr_rp].dst = hd.dst + `DDP_WORD_STEP;
      if (hd.cnt == 16'h0001) begin
        // Last write done: hand the code back to the channel side
        n.dfr_rp  = ~s.dfr_rp;
        n.dfr_cnt = n.dfr_cnt - 2'h1;
        if (!hd.early) pend_s[hd.code] = 1'b1;
        if (hd.chain) chn_s[hd.code] = 1'b1;
      end
    end

    // Stop handshakes; software should check for pending work first
    n.cc_ack = STOP_REQ_CC;
    n.tc_ack = STOP_REQ_TC & idle;

    // Flag update; a set in the same cycle as a clear wins
    n.evt  = (s.evt & ~evt_c) | EVT_IN;
    n.chn  = (s.chn & ~chn_c) | chn_s;
    n.man  = (s.man & ~man_c) | man_s;
    n.qev  = (s.qev & ~qev_c) | qev_s;
    n.sec  = (s.sec & ~sec_c) | sec_s;
    n.qsec = (s.qsec & ~qsec_c) | qsec_s;
    n.pend = (s.pend & ~pend_c) | pend_s;
  end

  // ------------------------------------------------------------
  // State register; CORE_CLK is the divide-by-three system clock
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s      <= '0;
      s.prio <= `DDP_PRIO_RST;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // Memories: no reset, so software must program every set first
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK) begin
    if (wr && phit) pmem[pidx] <= pmw;
    if (df_push) dfifo[s.df_wp] <= SRC_RDATA;
  end

  // ------------------------------------------------------------
  // Outputs, all from the state register
  // ------------------------------------------------------------
  assign WB_ACK      = s.ack;
  assign WB_DAT      = s.rdat;
  assign SRC_O.req   = s.src_req;
  assign SRC_O.addr  = s.rd_addr;
  assign DST_O.req   = s.dst_req;
  assign DST_O.addr  = s.waddr;
  assign DST_O.data  = s.wdat;
  assign SYS_PRIO    = s.prio;
  assign STOP_ACK_CC = s.cc_ack;
  assign STOP_ACK_TC = s.tc_ack;
endmodule

// ### testbench/ddp_chk.sv
// Port checker for the dispatch block
module ddp_chk (
  input wire logic              CORE_CLK,
  input wire logic              ARST_N,
  input wire ddp_pkg::ddp_wb_t  WB_I,
  input wire logic              WB_ACK,
  input wire ddp_pkg::ddp_src_t SRC_O,
  input wire logic              SRC_ACK,
  input wire ddp_pkg::ddp_dst_t DST_O,
  input wire logic              DST_ACK,
  input wire logic [2:0]        SYS_PRIO,
  input wire logic              STOP_REQ_CC,
  input wire logic              STOP_REQ_TC,
  input wire logic              STOP_ACK_CC,
  input wire logic              STOP_ACK_TC
);
  import ddp_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  property p_wb_ack; WB_I.cyc && WB_I.stb && !WB_ACK |=> WB_ACK; endproperty
  property p_ack_one; WB_ACK |=> !WB_ACK; endproperty
  property p_src_hold; SRC_O.req && !SRC_ACK |=> SRC_O.req && $stable(SRC_O.addr); endproperty
  property p_src_rel; SRC_O.req && SRC_ACK |=> !SRC_O.req; endproperty
  property p_dst_hold;
    DST_O.req && !DST_ACK |=> DST_O.req && $stable(DST_O.addr) && $stable(DST_O.data);
  endproperty
  property p_dst_rel; DST_O.req && DST_ACK |=> !DST_O.req; endproperty
  property p_stop_cc;
    (STOP_REQ_CC |=> STOP_ACK_CC) and (STOP_ACK_CC |-> $past(STOP_REQ_CC));
  endproperty
  // Idle means no command of either side is outstanding
  property p_stop_tc; STOP_ACK_TC |-> $past(STOP_REQ_TC) && !SRC_O.req && !DST_O.req; endproperty
  property p_prio; $changed(SYS_PRIO) |-> $past(WB_ACK) && $past(WB_I.we); endproperty

  a_wb_ack: assert property (p_wb_ack) else $error("bus ack missing");
  a_ack_one: assert property (p_ack_one) else $error("bus ack too long");
  a_src_hold: assert property (p_src_hold) else $error("read request moved");
  a_src_rel: assert property (p_src_rel) else $error("read request kept");
  a_dst_hold: assert property (p_dst_hold) else $error("write request moved");
  a_dst_rel: assert property (p_dst_rel) else $error("write request kept");
  a_stop_cc: assert property (p_stop_cc) else $error("channel stop ack wrong");
  a_stop_tc: assert property (p_stop_tc) else $error("engine stop ack wrong");
  a_prio: assert property (p_prio) else $error("priority changed alone");

  c_read: cover property (SRC_O.req && SRC_ACK);
  c_write: cover property (DST_O.req && DST_ACK);
  c_stop: cover property (STOP_ACK_TC);
endmodule

bind ddp_top ddp_chk i_ddp_chk (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .WB_I(WB_I), .WB_ACK(WB_ACK), .SRC_O(SRC_O),
  .SRC_ACK(SRC_ACK), .DST_O(DST_O), .DST_ACK(DST_ACK), .SYS_PRIO(SYS_PRIO),
  .STOP_REQ_CC(STOP_REQ_CC), .STOP_REQ_TC(STOP_REQ_TC), .STOP_ACK_CC(STOP_ACK_CC),
  .STOP_ACK_TC(STOP_ACK_TC)
);

// ### testbench/ddp_slave_mdl.sv
// Source and destination slave model with a programmable answer delay
module ddp_slave_mdl (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire ddp_pkg::ddp_src_t src,
  input  wire ddp_pkg::ddp_dst_t dst,
  input  wire logic [3:0]        lat,
  output logic                   src_ack,
  output logic [31:0]            src_rdata,
  output logic                   dst_ack
);
  import ddp_pkg::*;
  logic [3:0] wait_s_r;
  logic [3:0] wait_d_r;

  // Data is a scramble of the address; off the ack cycle it is inverted
  assign src_rdata = src_ack ? (src.addr ^ 32'ha5a5_0000) : ~(src.addr ^ 32'ha5a5_0000);

  // Each side waits lat cycles, acks once, then drops ack
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_s_r <= 4'h0;
      wait_d_r <= 4'h0;
      src_ack  <= 1'b0;
      dst_ack  <= 1'b0;
    end else begin
      wait_s_r <= (src.req && !src_ack && wait_s_r != lat) ? wait_s_r + 4'h1 : 4'h0;
      src_ack  <= src.req && !src_ack && wait_s_r == lat;
      wait_d_r <= (dst.req && !dst_ack && wait_d_r != lat) ? wait_d_r + 4'h1 : 4'h0;
      dst_ack  <= dst.req && !dst_ack && wait_d_r == lat;
    end
  end
endmodule

// ### testbench/ddp_top_tb.sv
// Self-checking bench for the event dispatch and transfer block
module ddp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ddp_pkg::*;
  logic        clk;
  logic        arst_n;
  ddp_wb_t     wb_i;
  logic        wb_ack;
  logic [31:0] wb_dat;
  logic [63:0] evt_in;
  ddp_src_t    src_o;
  logic        src_ack;
  logic [31:0] src_rdata;
  ddp_dst_t    dst_o;
  logic        dst_ack;
  logic [2:0]  sys_prio;
  logic        stop_cc;
  logic        stop_tc;
  logic        ack_cc;
  logic        ack_tc;
  logic [3:0]  lat;
  logic [31:0] log_a[$];
  logic [31:0] log_d[$];
  logic [31:0] q;
  int          n_fail;
  int          n_checks;

  ddp_top i_ddp_top (
    .CORE_CLK(clk), .ARST_N(arst_n), .WB_I(wb_i), .WB_ACK(wb_ack), .WB_DAT(wb_dat),
    .EVT_IN(evt_in), .SRC_O(src_o), .SRC_ACK(src_ack), .SRC_RDATA(src_rdata),
    .DST_O(dst_o), .DST_ACK(dst_ack), .SYS_PRIO(sys_prio), .STOP_REQ_CC(stop_cc),
    .STOP_REQ_TC(stop_tc), .STOP_ACK_CC(ack_cc), .STOP_ACK_TC(ack_tc)
  );
  ddp_slave_mdl i_ddp_slave_mdl (
    .clk(clk), .rst_n(arst_n), .src(src_o), .dst(dst_o), .lat(lat),
    .src_ack(src_ack), .src_rdata(src_rdata), .dst_ack(dst_ack)
  );

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Log accepted destination writes in order
  always @(posedge clk) begin
    if (dst_o.req && dst_ack) begin
      log_a.push_back(dst_o.addr);
      log_d.push_back(dst_o.data);
    end
  end

  // ----------------------------------------
  // Bus access and compare tasks
  // ----------------------------------------
  // One classic cycle; holds until ack is sampled, q takes the read data
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    @(posedge clk);
    while (wb_ack !== 1'b1) @(posedge clk);
    q = wb_dat;
    wb_i <= '0;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(n, e, q);
  endtask

  // Parameter set: options, count, source, destination
  task automatic prog(input int s, input logic [31:0] o, input logic [31:0] c,
                      input logic [31:0] sa, input logic [31:0] da);
    logic [11:0] b;
    b = 12'h400 + 12'(s * 16);
    wb(1'b1, b, o);
    wb(1'b1, b + 12'h4, c);
    wb(1'b1, b + 12'h8, sa);
    wb(1'b1, b + 12'hc, da);
  endtask

  // Polls a flag; a lost completion is cut short by the watchdog
  task automatic wait_bit(input logic [11:0] a, input int b);
    q = '0;
    while (q[b] !== 1'b1) wb(1'b0, a, '0);
  endtask

  task automatic chk_w(input int i, input logic [31:0] sa, input logic [31:0] da);
    chk("dst_addr", da, log_a[i]);
    chk("dst_data", sa ^ 32'ha5a5_0000, log_d[i]);
  endtask

  task automatic pulse(input logic [63:0] v);
    @(posedge clk);
    evt_in <= v;
    @(posedge clk);
    evt_in <= '0;
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial begin
    #2_000_000;
    n_fail++;
    results();
  end

  initial begin
    arst_n = 1'b0;
    wb_i = '0;
    evt_in = '0;
    stop_cc = 1'b0;
    stop_tc = 1'b0;
    lat = 4'h0;
    n_fail = 0;
    n_checks = 0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    chk("sys_prio", 32'h0, {29'h0, sys_prio});
    rc("status", 12'h048, 32'h0);
    wb(1'b1, 12'h044, 32'h5);
    rc("prio", 12'h044, 32'h5);
    chk("sys_prio", 32'h5, {29'h0, sys_prio});
    rc("unmapped", 12'h100, 32'h0);
    // Normal completion after both writes
    prog(3, 32'h3, 32'h2, 32'h1000, 32'h2000);
    wb(1'b1, 12'h010, 32'h8);
    wait_bit(12'h028, 3);
    chk("log_len", 32'h2, 32'(log_a.size()));
    chk_w(0, 32'h1000, 32'h2000);
    chk_w(1, 32'h1004, 32'h2004);
    rc("man_flag", 12'h010, 32'h0);
    rc("sec_flag", 12'h01c, 32'h0);
    wb(1'b1, 12'h028, 32'h8);
    rc("pend_clr", 12'h028, 32'h0);
    // Early completion, code 40, slow slave
    lat <= 4'hc;
    prog(12, 32'h4000_0028, 32'h4, 32'h1100, 32'h2100);
    wb(1'b1, 12'h010, 32'h1000);
    wait_bit(12'h02c, 8);
    chk("early_log", 32'h2, 32'(log_a.size()));
    while (log_a.size() < 6) @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      chk_w(2 + i, 32'h1100 + 32'(4 * i), 32'h2100 + 32'(4 * i));
    end
    // Quick set triggered by its last word
    prog(64, 32'h21, 32'h1, 32'h1800, 32'h2800);
    wait_bit(12'h02c, 1);
    chk_w(6, 32'h1800, 32'h2800);
    // Null set keeps flags, then dummy clears them without traffic
    prog(5, 32'h8000_0000, 32'h1, 32'h1200, 32'h2200);
    wb(1'b1, 12'h010, 32'h20);
    repeat (40) @(posedge clk);
    rc("null_sec", 12'h01c, 32'h20);
    rc("null_man", 12'h010, 32'h20);
    prog(5, 32'h0, 32'h0, 32'h1200, 32'h2200);
    wb(1'b1, 12'h01c, 32'h20);
    repeat (40) @(posedge clk);
    rc("dummy_man", 12'h010, 32'h0);
    rc("dummy_sec", 12'h01c, 32'h0);
    chk("no_write", 32'h7, 32'(log_a.size()));
    // Channel stop while idle: event latches, nothing dispatched
    prog(7, 32'h7, 32'h1, 32'h1300, 32'h2300);
    stop_cc <= 1'b1;
    pulse(64'h80);
    repeat (20) @(posedge clk);
    chk("ack_cc", 32'h1, {31'h0, ack_cc});
    rc("evt_flag", 12'h000, 32'h80);
    chk("stopped", 32'h7, 32'(log_a.size()));
    stop_cc <= 1'b0;
    wait_bit(12'h028, 7);
    chk_w(7, 32'h1300, 32'h2300);
    rc("evt_clr", 12'h000, 32'h0);
    // Program slot held full while channels 2, 4 (queue 1) and 9 arrive
    lat <= 4'h6;
    wb(1'b1, 12'h030, 32'h110);
    prog(20, 32'h14, 32'h4, 32'h1400, 32'h2400);
    prog(21, 32'h15, 32'h4, 32'h1480, 32'h2480);
    prog(2, 32'h2, 32'h1, 32'h1500, 32'h2500);
    prog(4, 32'h4, 32'h1, 32'h1600, 32'h2600);
    prog(9, 32'h9, 32'h1, 32'h1700, 32'h2700);
    wb(1'b1, 12'h010, 32'h0030_0000);
    while (src_o.req !== 1'b1) @(posedge clk);
    repeat (4) @(posedge clk);
    pulse(64'h214);
    repeat (4) @(posedge clk);
    rc("queued_sec", 12'h01c, 32'h214);
    while (log_a.size() < 19) @(posedge clk);
    chk_w(8, 32'h1400, 32'h2400);
    chk_w(12, 32'h1480, 32'h2480);
    chk_w(16, 32'h1700, 32'h2700);
    chk_w(17, 32'h1500, 32'h2500);
    chk_w(18, 32'h1600, 32'h2600);
    // Engine stop asked only once all traffic has ended
    stop_tc <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ack_tc", 32'h1, {31'h0, ack_tc});
    // Engine held: channel event beats quick, peripheral beats manual
    stop_cc <= 1'b1;
    prog(10, 32'ha, 32'h1, 32'h1900, 32'h2900);
    prog(65, 32'hb, 32'h1, 32'h1a00, 32'h2a00);
    wb(1'b1, 12'h010, 32'h400);
    pulse(64'h400);
    stop_cc <= 1'b0;
    repeat (6) @(posedge clk);
    rc("evt_first", 12'h000, 32'h0);
    rc("man_later", 12'h010, 32'h400);
    rc("qck_later", 12'h018, 32'h2);
    rc("qck_sec", 12'h024, 32'h2);
    stop_tc <= 1'b0;
    while (log_a.size() < 22) @(posedge clk);
    chk_w(19, 32'h1900, 32'h2900);
    chk_w(21, 32'h1a00, 32'h2a00);
    results();
  end
endmodule
